/* awh_asserts.sv */
// port checks for the timed-halt wake unit
module awh_asserts (
    input wire logic CLK_IN, RST_IN, AWVALID_IN, AWREADY_OUT, WVALID_IN, WREADY_OUT, BVALID_OUT,
    input wire logic HALT_EXEC_IN, EXIT_HALT_IRQ_IN, WDG_ENABLED_IN, WATCHDOG_HALT_OPTION_IN,
    input wire logic WAKE_RC_EN_OUT, CAPTURE_OUT, MAIN_OSC_ON_OUT, CPU_CLK_EN_OUT, CLR_IMASK_OUT,
    input wire logic WDG_RESET_OUT, WAKE_IRQ_OUT, WAKE_SERVICE_OUT, CC_PUSH_OUT
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);
    logic go, wdg;
    assign go = HALT_EXEC_IN && CPU_CLK_EN_OUT;
    assign wdg = WDG_ENABLED_IN && WATCHDOG_HALT_OPTION_IN;
    property p_enter; go && !wdg |=> CLR_IMASK_OUT && !CPU_CLK_EN_OUT && !MAIN_OSC_ON_OUT; endproperty
    a_enter: assert property (p_enter) else $error("halt entry wrong");
    property p_wdg; go && wdg |=> WDG_RESET_OUT && CPU_CLK_EN_OUT && !CLR_IMASK_OUT; endproperty
    a_wdg: assert property (p_wdg) else $error("watchdog halt wrong");
    property p_exit; EXIT_HALT_IRQ_IN && !MAIN_OSC_ON_OUT && !CPU_CLK_EN_OUT |=> MAIN_OSC_ON_OUT; endproperty
    a_exit: assert property (p_exit) else $error("exit interrupt ignored");
    property p_wake; $rose(WAKE_IRQ_OUT) |-> MAIN_OSC_ON_OUT && !WAKE_RC_EN_OUT && !CPU_CLK_EN_OUT; endproperty
    a_wake: assert property (p_wake) else $error("wake expiry wrong");
    property p_stab; $rose(WAKE_IRQ_OUT) |-> ##64 WAKE_SERVICE_OUT; endproperty
    a_stab: assert property (p_stab) else $error("stabilisation delay wrong");
    property p_push; WAKE_SERVICE_OUT |-> CC_PUSH_OUT && CPU_CLK_EN_OUT; endproperty
    a_push: assert property (p_push) else $error("state not pushed");
    property p_cap; CAPTURE_OUT |-> WAKE_RC_EN_OUT && CPU_CLK_EN_OUT; endproperty
    a_cap: assert property (p_cap) else $error("capture outside measure");
    property p_osc; !MAIN_OSC_ON_OUT |-> !CPU_CLK_EN_OUT; endproperty
    a_osc: assert property (p_osc) else $error("cpu clocked without oscillator");
    property p_bus; AWVALID_IN && AWREADY_OUT && WVALID_IN && WREADY_OUT |-> ##2 BVALID_OUT; endproperty
    a_bus: assert property (p_bus) else $error("write response late");
    c_svc: cover property (WAKE_SERVICE_OUT);
    c_wdg: cover property (WDG_RESET_OUT);
    c_cap: cover property (CAPTURE_OUT);
endmodule
bind awh_top awh_asserts awh_asserts_inst (.*);

/* awh_pkg.sv */
// constants, register map and types of the timed-halt wake unit
package awh_pkg;
    localparam int               ADDR_W          = 12;
    // register indices; byte address is four times the index
    localparam logic [7:0]       PRESC_IDX       = 8'h49;
    localparam logic [7:0]       CSR_IDX         = 8'h4a;
    localparam logic [7:0]       INT_STAT_IDX    = 8'h4b;
    localparam logic [7:0]       INT_CLR_IDX     = 8'h4c;
    localparam logic [7:0]       INT_EN_IDX      = 8'h4d;
    localparam logic [7:0]       PRIO_IDX        = 8'h4e;
    localparam logic [ADDR_W-1:0] PRESC_ADDR     = {2'b00, PRESC_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] CSR_ADDR       = {2'b00, CSR_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] INT_STAT_ADDR  = {2'b00, INT_STAT_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] INT_CLR_ADDR   = {2'b00, INT_CLR_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] INT_EN_ADDR    = {2'b00, INT_EN_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] PRIO_ADDR      = {2'b00, PRIO_IDX, 2'b00};
    // control/status field positions
    localparam int               WAKE_EN_BIT     = 0;
    localparam int               MEAS_BIT        = 1;
    localparam int               FLAG_BIT        = 2;
    // interrupt status bit positions
    localparam int               EV_WAKE_BIT     = 0;
    localparam int               EV_EXIT_BIT     = 1;
    localparam int               EV_WDG_BIT      = 2;
    // values after reset
    localparam logic [7:0]       PRESC_RESET     = 8'hff;
    localparam logic [7:0]       CSR_RESET       = 8'h00;
    localparam logic [2:0]       INT_EN_RESET    = 3'h0;
    localparam logic [1:0]       PRIO_RESET      = 2'h2;
    // counts
    localparam logic [5:0]       FIX_DIV_LAST    = 6'h3f;
    localparam logic [3:0]       RC_START_EDGES  = 4'h8;
    localparam logic [6:0]       STAB_CYCLES     = 7'h40;
    // bus answers
    localparam logic [1:0]       RESP_OKAY       = 2'h0;
    localparam logic [1:0]       RESP_SLVERR     = 2'h2;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_RC_START,
        ST_COUNT,
        ST_PLAIN_HALT,
        ST_STABILISE
    } awh_state_e;
endpackage

/* awh_rc_model.sv */
// wake rc oscillator model: free of the system clock, still while disabled
module awh_rc_model (
    input  wire logic en_in,
    output logic      rc_out,
    output int        edges_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        rc_out = 1'b0;
        edges_out = 0;
        forever begin
            #47;
            rc_out = en_in ? ~rc_out : 1'b0;
            if (en_in && rc_out) edges_out++;
        end
    end
endmodule

/* awh_top.sv */
// timed-halt wake unit with AXI4-Lite register slave
// Summary of operation
// - halt instruction with wake_enable set enters timed halt instead of plain halt
// - in timed halt the RC oscillator drives fixed divider then wake_prescaler
// - halt time is 64 x prescaler RC periods plus oscillator start-up time
// - on expiry set wake_flag, raise wake interrupt, restart main oscillator for 64 cycles
// - after stabilisation the CPU resumes by servicing the wake interrupt
// - reading wake_ctrl_status clears wake_flag and its pending interrupt request
// - software writes to the wake_flag bit are ignored
// - osc_measure_enable in run mode enables RC and routes it to lite timer capture
// - wake_enable changes only by software writes, kept across halt entry
// - prescaler divides by its value 01h to FFh, 00h forbidden, resets to FFh
// - writing 00h either forces immediate interrupt after halt or is ignored
// - timed halt ends on reset, exit-capable interrupt, or wake interrupt
// - entering halt forces the interrupt mask bit of condition_code_reg to 0
// - during halt main oscillator stops, only other-clocked peripherals run
// - watchdog_halt_option decides whether halt with watchdog on gives a reset
// - before servicing, push condition_code_reg and set its level bits to priority
module awh_top
    import awh_pkg::*;
#(
    parameter bit ZERO_PRESC_IGNORED = 1'b1
) (
    input  wire logic              CLK_IN,
    input  wire logic              RST_IN,
    input  wire logic [ADDR_W-1:0] AWADDR_IN,
    input  wire logic              AWVALID_IN,
    output logic                   AWREADY_OUT,
    input  wire logic [31:0]       WDATA_IN,
    input  wire logic [3:0]        WSTRB_IN,
    input  wire logic              WVALID_IN,
    output logic                   WREADY_OUT,
    output logic [1:0]             BRESP_OUT,
    output logic                   BVALID_OUT,
    input  wire logic              BREADY_IN,
    input  wire logic [ADDR_W-1:0] ARADDR_IN,
    input  wire logic              ARVALID_IN,
    output logic                   ARREADY_OUT,
    output logic [31:0]            RDATA_OUT,
    output logic [1:0]             RRESP_OUT,
    output logic                   RVALID_OUT,
    input  wire logic              RREADY_IN,
    input  wire logic              HALT_EXEC_IN,
    input  wire logic              EXIT_HALT_IRQ_IN,
    input  wire logic              WDG_ENABLED_IN,
    input  wire logic              WATCHDOG_HALT_OPTION_IN,
    input  wire logic              WAKE_RC_CLK_IN,
    output logic                   WAKE_RC_EN_OUT,
    output logic                   CAPTURE_OUT,
    output logic                   MAIN_OSC_ON_OUT,
    output logic                   CPU_CLK_EN_OUT,
    output logic                   CLR_IMASK_OUT,
    output logic                   WDG_RESET_OUT,
    output logic                   WAKE_IRQ_OUT,
    output logic                   WAKE_SERVICE_OUT,
    output logic                   CC_PUSH_OUT,
    output logic [1:0]             IRQ_LEVEL_OUT,
    output logic                   IRQ_OUT
);

    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        addr_mapped = (a == PRESC_ADDR) || (a == CSR_ADDR) || (a == INT_STAT_ADDR) ||
                      (a == INT_CLR_ADDR) || (a == INT_EN_ADDR) || (a == PRIO_ADDR);
    endfunction

    // bus group
    logic [ADDR_W-1:0] awaddr_reg,  awaddr_next;
    logic              aw_held_reg, aw_held_next;
    logic [7:0]        wdata_reg,   wdata_next;
    logic              wstrb0_reg,  wstrb0_next;
    logic              w_held_reg,  w_held_next;
    logic              awready_reg, awready_next;
    logic              wready_reg,  wready_next;
    logic              bvalid_reg,  bvalid_next;
    logic [1:0]        bresp_reg,   bresp_next;
    logic              arready_reg, arready_next;
    logic              rvalid_reg,  rvalid_next;
    logic [1:0]        rresp_reg,   rresp_next;
    logic [31:0]       rdata_reg,   rdata_next;
    logic              wr_fire;
    logic              ar_fire;
    logic [7:0]        read_value;

    // register and sequencer group
    logic [7:0]        presc_reg,     presc_next;
    logic              wake_en_reg,   wake_en_next;
    logic              meas_reg,      meas_next;
    logic              flag_reg,      flag_next;
    logic [2:0]        int_stat_reg,  int_stat_next;
    logic [2:0]        int_en_reg,    int_en_next;
    logic [1:0]        prio_reg,      prio_next;
    awh_state_e        state_reg,     state_next;
    logic [3:0]        start_cnt_reg, start_cnt_next;
    logic [5:0]        div_cnt_reg,   div_cnt_next;
    logic [7:0]        presc_cnt_reg, presc_cnt_next;
    logic [6:0]        stab_cnt_reg,  stab_cnt_next;
    logic              by_wake_reg,   by_wake_next;
    logic              rc_lvl_reg,    rc_lvl_next;
    logic              rc_en_reg,     rc_en_next;
    logic              capture_reg,   capture_next;
    logic              osc_on_reg,    osc_on_next;
    logic              cpu_en_reg,    cpu_en_next;
    logic              clr_imask_reg, clr_imask_next;
    logic              wdg_rst_reg,   wdg_rst_next;
    logic              wake_irq_reg,  wake_irq_next;
    logic              service_reg,   service_next;
    logic              cc_push_reg,   cc_push_next;
    logic [1:0]        irq_lvl_reg,   irq_lvl_next;
    logic              irq_reg,       irq_next;
    logic              rc_edge;
    logic              expire;
    logic              early_exit;
    logic              wdg_event;

    // wake rc arrives from another clock: three stages, only s2/s3 are compared
    logic rc_s1_reg;
    logic rc_s2_reg;
    logic rc_s3_reg;

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            rc_s1_reg <= 1'b0;
            rc_s2_reg <= 1'b0;
            rc_s3_reg <= 1'b0;
        end else begin
            rc_s1_reg <= WAKE_RC_CLK_IN;
            rc_s2_reg <= rc_s1_reg;
            rc_s3_reg <= rc_s2_reg;
        end
    end

    assign wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;
    assign ar_fire = ARVALID_IN & arready_reg;

    always_comb begin
        case (ARADDR_IN)
            PRESC_ADDR:    read_value = presc_reg;
            CSR_ADDR:      read_value = {5'h00, flag_reg, meas_reg, wake_en_reg};
            INT_STAT_ADDR: read_value = {5'h00, int_stat_reg};
            INT_EN_ADDR:   read_value = {5'h00, int_en_reg};
            PRIO_ADDR:     read_value = {6'h00, prio_reg};
            default:       read_value = 8'h00;
        endcase
    end

    always_comb begin
        awaddr_next  = awaddr_reg;
        aw_held_next = aw_held_reg;
        wdata_next   = wdata_reg;
        wstrb0_next  = wstrb0_reg;
        w_held_next  = w_held_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        rvalid_next  = rvalid_reg;
        rresp_next   = rresp_reg;
        rdata_next   = rdata_reg;
        if (AWVALID_IN && awready_reg) begin
            aw_held_next = 1'b1;
            awaddr_next  = AWADDR_IN;
        end
        if (WVALID_IN && wready_reg) begin
            w_held_next = 1'b1;
            wdata_next  = WDATA_IN[7:0];
            wstrb0_next = WSTRB_IN[0];
        end
        if (bvalid_reg && BREADY_IN) begin
            bvalid_next = 1'b0;
        end
        if (wr_fire) begin
            bvalid_next  = 1'b1;
            bresp_next   = addr_mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
            aw_held_next = 1'b0;
            w_held_next  = 1'b0;
        end
        if (rvalid_reg && RREADY_IN) begin
            rvalid_next = 1'b0;
        end
        if (ar_fire) begin
            rvalid_next = 1'b1;
            rdata_next  = {24'h000000, read_value};
            rresp_next  = addr_mapped(ARADDR_IN) ? RESP_OKAY : RESP_SLVERR;
        end
        // one outstanding transfer per direction keeps the slave free of queues
        awready_next = ~aw_held_next;
        wready_next  = ~w_held_next;
        arready_next = ~rvalid_next;
    end

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            awaddr_reg  <= '0;
            aw_held_reg <= 1'b0;
            wdata_reg   <= 8'h00;
            wstrb0_reg  <= 1'b0;
            w_held_reg  <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
            rresp_reg   <= RESP_OKAY;
            rdata_reg   <= 32'h00000000;
        end else begin
            awaddr_reg  <= awaddr_next;
            aw_held_reg <= aw_held_next;
            wdata_reg   <= wdata_next;
            wstrb0_reg  <= wstrb0_next;
            w_held_reg  <= w_held_next;
            awready_reg <= awready_next;
            wready_reg  <= wready_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg  <= rvalid_next;
            rresp_reg   <= rresp_next;
            rdata_reg   <= rdata_next;
        end
    end

    always_comb begin
        presc_next     = presc_reg;
        wake_en_next   = wake_en_reg;
        meas_next      = meas_reg;
        flag_next      = flag_reg;
        int_stat_next  = int_stat_reg;
        int_en_next    = int_en_reg;
        prio_next      = prio_reg;
        state_next     = state_reg;
        start_cnt_next = start_cnt_reg;
        div_cnt_next   = div_cnt_reg;
        presc_cnt_next = presc_cnt_reg;
        stab_cnt_next  = stab_cnt_reg;
        by_wake_next   = by_wake_reg;
        clr_imask_next = 1'b0;
        wdg_rst_next   = 1'b0;
        service_next   = 1'b0;
        cc_push_next   = 1'b0;
        irq_lvl_next   = irq_lvl_reg;
        expire         = 1'b0;
        early_exit     = 1'b0;
        wdg_event      = 1'b0;
        rc_lvl_next    = (rc_s2_reg == rc_s3_reg) ? rc_s3_reg : rc_lvl_reg;
        rc_edge        = rc_lvl_next & ~rc_lvl_reg;

        if (wr_fire && wstrb0_reg) begin
            case (awaddr_reg)
                PRESC_ADDR: begin
                    if (wdata_reg != 8'h00 || !ZERO_PRESC_IGNORED) begin
                        presc_next = wdata_reg;
                    end
                end
                CSR_ADDR: begin
                    wake_en_next = wdata_reg[WAKE_EN_BIT];
                    meas_next    = wdata_reg[MEAS_BIT];
                end
                INT_CLR_ADDR: int_stat_next = int_stat_reg & ~wdata_reg[2:0];
                INT_EN_ADDR:  int_en_next   = wdata_reg[2:0];
                PRIO_ADDR:    prio_next     = wdata_reg[1:0];
                default: begin
                end
            endcase
        end
        if (ar_fire && ARADDR_IN == CSR_ADDR) begin
            flag_next = 1'b0;
        end

        case (state_reg)
            ST_RUN: begin
                if (HALT_EXEC_IN) begin
                    if (WDG_ENABLED_IN && WATCHDOG_HALT_OPTION_IN) begin
                        wdg_rst_next = 1'b1;
                        wdg_event    = 1'b1;
                    end else begin
                        clr_imask_next = 1'b1;
                        by_wake_next   = 1'b0;
                        start_cnt_next = 4'h0;
                        div_cnt_next   = 6'h00;
                        presc_cnt_next = 8'h00;
                        if (!wake_en_reg) begin
                            state_next = ST_PLAIN_HALT;
                        end else if (presc_reg == 8'h00) begin
                            // forbidden value kept: wake at once after halt
                            expire     = 1'b1;
                            state_next = ST_STABILISE;
                        end else begin
                            state_next = ST_RC_START;
                        end
                    end
                end
            end
            ST_RC_START: begin
                if (EXIT_HALT_IRQ_IN) begin
                    early_exit = 1'b1;
                    state_next = ST_STABILISE;
                end else if (rc_edge) begin
                    start_cnt_next = 4'(start_cnt_reg + 4'h1);
                    if (start_cnt_next == RC_START_EDGES) begin
                        state_next = ST_COUNT;
                    end
                end
            end
            ST_COUNT: begin
                if (EXIT_HALT_IRQ_IN) begin
                    early_exit = 1'b1;
                    state_next = ST_STABILISE;
                end else if (rc_edge) begin
                    div_cnt_next = 6'(div_cnt_reg + 6'h01);
                    if (div_cnt_reg == FIX_DIV_LAST) begin
                        presc_cnt_next = 8'(presc_cnt_reg + 8'h01);
                        if (presc_cnt_next == presc_reg) begin
                            expire     = 1'b1;
                            state_next = ST_STABILISE;
                        end
                    end
                end
            end
            ST_PLAIN_HALT: begin
                if (EXIT_HALT_IRQ_IN) begin
                    early_exit = 1'b1;
                    state_next = ST_STABILISE;
                end
            end
            ST_STABILISE: begin
                stab_cnt_next = 7'(stab_cnt_reg + 7'h01);
                if (stab_cnt_next == STAB_CYCLES) begin
                    state_next = ST_RUN;
                    if (by_wake_reg) begin
                        service_next = 1'b1;
                        cc_push_next = 1'b1;
                        irq_lvl_next = prio_reg;
                    end
                end
            end
            default: state_next = ST_RUN;
        endcase

        if (state_next == ST_STABILISE && state_reg != ST_STABILISE) begin
            stab_cnt_next = 7'h00;
        end
        if (expire) begin
            flag_next    = 1'b1;
            by_wake_next = 1'b1;
        end
        // hardware events win over a clear in the same cycle
        if (expire) begin
            int_stat_next[EV_WAKE_BIT] = 1'b1;
        end
        if (early_exit) begin
            int_stat_next[EV_EXIT_BIT] = 1'b1;
        end
        if (wdg_event) begin
            int_stat_next[EV_WDG_BIT] = 1'b1;
        end

        wake_irq_next = flag_next;
        irq_next      = |(int_stat_next & int_en_next);
        // main clock only while running or settling after any halt exit
        osc_on_next   = (state_next == ST_RUN) || (state_next == ST_STABILISE);
        cpu_en_next   = (state_next == ST_RUN);
        rc_en_next    = (meas_next && state_next == ST_RUN) ||
                        (state_next == ST_RC_START) || (state_next == ST_COUNT);
        capture_next  = meas_next && state_next == ST_RUN && rc_lvl_next;
    end

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            presc_reg     <= PRESC_RESET;
            wake_en_reg   <= CSR_RESET[WAKE_EN_BIT];
            meas_reg      <= CSR_RESET[MEAS_BIT];
            flag_reg      <= CSR_RESET[FLAG_BIT];
            int_stat_reg  <= 3'h0;
            int_en_reg    <= INT_EN_RESET;
            prio_reg      <= PRIO_RESET;
            state_reg     <= ST_RUN;
            start_cnt_reg <= 4'h0;
            div_cnt_reg   <= 6'h00;
            presc_cnt_reg <= 8'h00;
            stab_cnt_reg  <= 7'h00;
            by_wake_reg   <= 1'b0;
            rc_lvl_reg    <= 1'b0;
            rc_en_reg     <= 1'b0;
            capture_reg   <= 1'b0;
            osc_on_reg    <= 1'b1;
            cpu_en_reg    <= 1'b1;
            clr_imask_reg <= 1'b0;
            wdg_rst_reg   <= 1'b0;
            wake_irq_reg  <= 1'b0;
            service_reg   <= 1'b0;
            cc_push_reg   <= 1'b0;
            irq_lvl_reg   <= 2'h0;
            irq_reg       <= 1'b0;
        end else begin
            presc_reg     <= presc_next;
            wake_en_reg   <= wake_en_next;
            meas_reg      <= meas_next;
            flag_reg      <= flag_next;
            int_stat_reg  <= int_stat_next;
            int_en_reg    <= int_en_next;
            prio_reg      <= prio_next;
            state_reg     <= state_next;
            start_cnt_reg <= start_cnt_next;
            div_cnt_reg   <= div_cnt_next;
            presc_cnt_reg <= presc_cnt_next;
            stab_cnt_reg  <= stab_cnt_next;
            by_wake_reg   <= by_wake_next;
            rc_lvl_reg    <= rc_lvl_next;
            rc_en_reg     <= rc_en_next;
            capture_reg   <= capture_next;
            osc_on_reg    <= osc_on_next;
            cpu_en_reg    <= cpu_en_next;
            clr_imask_reg <= clr_imask_next;
            wdg_rst_reg   <= wdg_rst_next;
            wake_irq_reg  <= wake_irq_next;
            service_reg   <= service_next;
            cc_push_reg   <= cc_push_next;
            irq_lvl_reg   <= irq_lvl_next;
            irq_reg       <= irq_next;
        end
    end

    assign AWREADY_OUT      = awready_reg;
    assign WREADY_OUT       = wready_reg;
    assign BRESP_OUT        = bresp_reg;
    assign BVALID_OUT       = bvalid_reg;
    assign ARREADY_OUT      = arready_reg;
    assign RDATA_OUT        = rdata_reg;
    assign RRESP_OUT        = rresp_reg;
    assign RVALID_OUT       = rvalid_reg;
    assign WAKE_RC_EN_OUT   = rc_en_reg;
    assign CAPTURE_OUT      = capture_reg;
    assign MAIN_OSC_ON_OUT  = osc_on_reg;
    assign CPU_CLK_EN_OUT   = cpu_en_reg;
    assign CLR_IMASK_OUT    = clr_imask_reg;
    assign WDG_RESET_OUT    = wdg_rst_reg;
    assign WAKE_IRQ_OUT     = wake_irq_reg;
    assign WAKE_SERVICE_OUT = service_reg;
    assign CC_PUSH_OUT      = cc_push_reg;
    assign IRQ_LEVEL_OUT    = irq_lvl_reg;
    assign IRQ_OUT          = irq_reg;

endmodule

/* test_auto_wakeup_from_halt.sv */
// self-checking bench for the timed-halt wake unit
module test_auto_wakeup_from_halt
    import awh_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic [ADDR_W-1:0] AWADDR_IN, ARADDR_IN;
    logic [31:0] WDATA_IN, RDATA_OUT, seed, rd;
    logic [3:0] WSTRB_IN;
    logic [1:0] BRESP_OUT, RRESP_OUT, IRQ_LEVEL_OUT, rsp;
    logic CLK_IN, RST_IN, AWVALID_IN, AWREADY_OUT, WVALID_IN, WREADY_OUT, BVALID_OUT, BREADY_IN;
    logic ARVALID_IN, ARREADY_OUT, RVALID_OUT, RREADY_IN, HALT_EXEC_IN, EXIT_HALT_IRQ_IN;
    logic WDG_ENABLED_IN, WATCHDOG_HALT_OPTION_IN, WAKE_RC_CLK_IN, WAKE_RC_EN_OUT, CAPTURE_OUT;
    logic MAIN_OSC_ON_OUT, CPU_CLK_EN_OUT, CLR_IMASK_OUT, WDG_RESET_OUT, WAKE_IRQ_OUT;
    logic WAKE_SERVICE_OUT, CC_PUSH_OUT, IRQ_OUT;
    logic [7:0] p, pr;
    int failures, check_count, edges, e0;
    awh_top awh_top_inst (.*);
    awh_rc_model awh_rc_model_inst (.en_in(WAKE_RC_EN_OUT), .rc_out(WAKE_RC_CLK_IN), .edges_out(edges));
    initial begin
        CLK_IN = 1'b0;
        forever #5 CLK_IN = ~CLK_IN;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // start-up edges plus 64 per prescaler step
    function automatic logic [31:0] rc_exp(input logic [7:0] v);
        return 32'(RC_START_EDGES) + 32'd64 * v;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        bit ta, tw;
        ta = 0;
        tw = 0;
        @(posedge CLK_IN);
        AWADDR_IN <= a;
        WDATA_IN <= {24'h0, d};
        {AWVALID_IN, WVALID_IN, BREADY_IN} <= 3'h7;
        while (!(ta && tw)) begin
            @(posedge CLK_IN);
            if (AWREADY_OUT && !ta) begin
                ta = 1;
                AWVALID_IN <= 1'b0;
            end
            if (WREADY_OUT && !tw) begin
                tw = 1;
                WVALID_IN <= 1'b0;
            end
        end
        do @(posedge CLK_IN); while (!BVALID_OUT);
        rsp = BRESP_OUT;
        BREADY_IN <= 1'b0;
    endtask
    task automatic rdr(input logic [ADDR_W-1:0] a);
        @(posedge CLK_IN);
        ARADDR_IN <= a;
        {ARVALID_IN, RREADY_IN} <= 2'h3;
        do @(posedge CLK_IN); while (!ARREADY_OUT);
        ARVALID_IN <= 1'b0;
        do @(posedge CLK_IN); while (!RVALID_OUT);
        rd = RDATA_OUT;
        rsp = RRESP_OUT;
        RREADY_IN <= 1'b0;
    endtask
    task automatic halt();
        @(posedge CLK_IN);
        HALT_EXEC_IN <= 1'b1;
        @(posedge CLK_IN);
        HALT_EXEC_IN <= 1'b0;
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // generous bound: the longest halt is just under 20 us
    initial begin
        #500000;
        failures++;
        complete_run();
    end
    initial begin
        failures = 0;
        check_count = 0;
        seed = 32'd38;
        RST_IN = 1'b1;
        {AWVALID_IN, WVALID_IN, BREADY_IN, ARVALID_IN, RREADY_IN, HALT_EXEC_IN} = '0;
        {EXIT_HALT_IRQ_IN, WDG_ENABLED_IN, WATCHDOG_HALT_OPTION_IN, AWADDR_IN, ARADDR_IN, WDATA_IN} = '0;
        WSTRB_IN = 4'hf;
        repeat (5) @(posedge CLK_IN);
        RST_IN <= 1'b0;
        rdr(PRESC_ADDR); chk(rd, {24'h0, PRESC_RESET});
        rdr(CSR_ADDR); chk(rd, {24'h0, CSR_RESET});
        wr(PRESC_ADDR, 8'h00); rdr(PRESC_ADDR); chk(rd, 32'hff);
        rdr(12'h3f0); chk({rd[29:0], rsp}, {30'h0, RESP_SLVERR});
        wr(CSR_ADDR, 8'h07); rdr(CSR_ADDR); chk(rd, 32'h3);
        repeat (12) @(posedge CLK_IN); chk(WAKE_RC_EN_OUT, 1);
        do @(posedge CLK_IN); while (!CAPTURE_OUT);
        $display("test registers done");
        wr(INT_EN_ADDR, 8'h07);
        for (int i = 0; i < 2; i++) begin
            p = (i == 0) ? 8'h01 : 8'(rnd() % 3 + 1);
            pr = 8'(rnd() & 32'h3);
            wr(PRESC_ADDR, p); wr(PRIO_ADDR, pr); wr(CSR_ADDR, 8'h01);
            repeat (20) @(posedge CLK_IN);
            chk(CAPTURE_OUT, 0);
            halt();
            e0 = edges;
            do @(posedge CLK_IN); while (!WAKE_IRQ_OUT);
            chk(32'(edges - e0), rc_exp(p));
            chk(IRQ_OUT, 1);
            do @(posedge CLK_IN); while (!WAKE_SERVICE_OUT);
            chk({CC_PUSH_OUT, IRQ_LEVEL_OUT}, {1'b1, pr[1:0]});
            rdr(CSR_ADDR); chk(rd, 32'h5);
            rdr(CSR_ADDR); chk(rd, 32'h1);
            chk(WAKE_IRQ_OUT, 0);
            rdr(INT_STAT_ADDR); chk(rd, 32'h1);
            wr(INT_CLR_ADDR, 8'h01); chk(IRQ_OUT, 0);
        end
        $display("test timed halt done");
        wr(CSR_ADDR, 8'h00); halt();
        repeat (20) @(posedge CLK_IN);
        chk({CPU_CLK_EN_OUT, MAIN_OSC_ON_OUT, WAKE_RC_EN_OUT}, 0);
        EXIT_HALT_IRQ_IN <= 1'b1;
        do @(posedge CLK_IN); while (!CPU_CLK_EN_OUT);
        EXIT_HALT_IRQ_IN <= 1'b0;
        rdr(INT_STAT_ADDR); chk(rd, 32'h2);
        $display("test plain halt done");
        {WDG_ENABLED_IN, WATCHDOG_HALT_OPTION_IN} <= 2'h3;
        halt();
        repeat (3) @(posedge CLK_IN);
        chk(CPU_CLK_EN_OUT, 1);
        rdr(INT_STAT_ADDR); chk(rd, 32'h6);
        $display("test watchdog done");
        WDG_ENABLED_IN <= 1'b0;
        halt();
        RST_IN <= 1'b1;
        repeat (4200) @(posedge CLK_IN);
        RST_IN <= 1'b0;
        rdr(PRESC_ADDR); chk(rd, {24'h0, PRESC_RESET});
        $display("test reset done");
        complete_run();
    end
endmodule
